// ---- rst_irq_defines.svh ----
`ifndef RST_IRQ_DEFINES_SVH
`define RST_IRQ_DEFINES_SVH
// ----------------------------------------------------------------
// Vector addresses (high byte address; low byte is +1)
// ----------------------------------------------------------------
`define VEC_RESET 16'hFFFE
`define VEC_TRAP 16'hFFEE
`define VEC_NONMASK 16'hFFFC
`define VEC_SOFTWARE 16'hFFFA
`define VEC_EXTERNAL 16'hFFF8
`define VEC_CAPTURE 16'hFFF6
`define VEC_COMPARE 16'hFFF4
`define VEC_WRAP 16'hFFF2
`define VEC_SERIAL 16'hFFF0
// ----------------------------------------------------------------
// RAM control register
// ----------------------------------------------------------------
`define RAM_CTRL_ADDR 16'h0014
`define RAM_CTRL_ALLOW_BIT 6
`define RAM_CTRL_RESET 8'h40
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define E_DIVIDE 4
`define E_DIVIDE_HALF 2
`define PUSH_CYCLES 4'h7
`endif

// ---- rst_irq_pkg.sv ----
package rst_irq_pkg;
    // Sequencer states
    typedef enum logic [2:0] {
        ST_HOLD = 3'b000,
        ST_FETCH_HI = 3'b001,
        ST_FETCH_LO = 3'b010,
        ST_RUN = 3'b011,
        ST_PUSH = 3'b100
    } seq_state_type;

    // Serviced source codes
    typedef enum logic [3:0] {
        SRC_NONE = 4'h0,
        SRC_RESET = 4'h1,
        SRC_TRAP = 4'h2,
        SRC_NONMASK = 4'h3,
        SRC_SOFTWARE = 4'h4,
        SRC_EXTERNAL = 4'h5,
        SRC_CAPTURE = 4'h6,
        SRC_COMPARE = 4'h7,
        SRC_WRAP = 4'h8,
        SRC_SERIAL = 4'h9
    } src_type;
endpackage

// ---- reset_interrupt_sequencer.sv ----
`timescale 1ns/1ps
`include "rst_irq_defines.svh"
// Contract
// - Standby low stops oscillator, freezes internal clock, resets device.
// - RAM enable is bit 6 of RAM control at 0014; clear keeps RAM.
// - Address outputs float while reset is low.
// - Ports float at once on reset; internal logic resets with clock.
// - Reset rising edge latches port 2 pins 2..0 into mode bits.
// - After reset, PC loads from FFFE (high) and FFFF (low).
// - Reset sets interrupt mask; software clears it for maskable sources.
// - E output runs at one quarter of the crystal rate.
// - Non-maskable falling edge serviced after current instruction, mask ignored.
// - Non-maskable stacks registers then vectors via FFFC/FFFD.
// - External maskable is level-sensitive, taken at boundary only if unmasked.
// - Maskable sequence stacks registers then sets the mask.
// - External maskable vectors via FFF8/FFF9.
// - Internal peripheral requests form second maskable request with own vectors.
// - External beats internal when both pend; mask blocks both.
// - External maskable request is not latched.
// - Fixed priority: reset, trap, NMI, SOFTWARE_EXCEPTION, external, capture, compare, wrap, serial.
// - Address or opcode error raises trap, ignores mask, vectors FFEE/FFEF.
// - Single-chip strobe falling edge sets port-3 strobe flag feeding external.
// - Strobe flag requests only with its enable set; reset clears enable.
module reset_interrupt_sequencer
    import rst_irq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic chip_reset_pin,
    input wire logic low_power_hold_pin,
    input wire logic nonmask_pin,
    input wire logic external_maskable_request,
    input wire logic port_in_strobe,
    input wire logic [2:0] port2_mode_pins,
    input wire logic single_chip_mode,
    input wire logic capture_event_flag,
    input wire logic compare_event_flag,
    input wire logic counter_wrap_flag,
    input wire logic serial_unit_event,
    input wire logic software_exception,
    input wire logic address_error,
    input wire logic opcode_error,
    input wire logic instr_boundary,
    input wire logic mask_clear,
    input wire logic mask_set,
    input wire logic strobe_irq_enable_wr,
    input wire logic strobe_irq_enable_data,
    input wire logic strobe_flag_clear,
    input wire logic ram_ctrl_wr,
    input wire logic [7:0] ram_ctrl_data,
    input wire logic [7:0] vector_data,
    output logic e_clk,
    output logic osc_enable,
    output logic ports_oe_n,
    output logic addr_oe_n,
    output logic [15:0] vector_addr,
    output logic vector_read,
    output logic [15:0] program_counter,
    output logic pc_valid,
    output logic stack_push,
    output logic [3:0] service_source,
    output logic interrupt_mask,
    output logic [2:0] op_config,
    output logic strobe_flag,
    output logic strobe_irq_enable,
    output logic ram_access_allow
);

// ----------------------------------------------------------------
// Clock divide and reset conditioning
// ----------------------------------------------------------------
logic [1:0] div_count;
logic e_rise;
logic [2:0] rst_sync;
logic [2:0] low_power_hold_pin_sync;
logic rst_low;
logic low_power_hold_pin_low;
logic reset_active;
logic reset_prev;
logic reset_release;

// Crystal divided by four for E; phase count gated off in standby
always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        div_count <= 2'h0;
        e_clk <= 1'b0;
    end else if (low_power_hold_pin_low) begin
        div_count <= 2'h0;
        e_clk <= 1'b0;
    end else begin
        div_count <= div_count + 2'h1;
        e_clk <= (div_count + 2'h1) >= 2'(`E_DIVIDE_HALF);
    end
end
assign e_rise = (div_count == 2'h1);

// Three-stage synchronisers for reset and standby pins
always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        rst_sync <= 3'h0;
        low_power_hold_pin_sync <= 3'h0;
        rst_low <= 1'b1;
        low_power_hold_pin_low <= 1'b1;
    end else begin
        rst_sync <= {rst_sync[1:0], chip_reset_pin};
        low_power_hold_pin_sync <= {low_power_hold_pin_sync[1:0], low_power_hold_pin};
        // A level counts only once the last two stages agree, so a glitch never toggles
        if (rst_sync[1] == rst_sync[2]) begin
            rst_low <= !rst_sync[2];
        end
        if (low_power_hold_pin_sync[1] == low_power_hold_pin_sync[2]) begin
            low_power_hold_pin_low <= !low_power_hold_pin_sync[2];
        end
    end
end

// Standby forces reset; internal logic resets on the clock
assign reset_active = rst_low || low_power_hold_pin_low;
assign osc_enable = low_power_hold_pin;
// Raw pin drives the floats so they act without a clock edge
assign ports_oe_n = !chip_reset_pin || !low_power_hold_pin;
assign addr_oe_n = !chip_reset_pin || !low_power_hold_pin || !pc_valid;

always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        reset_prev <= 1'b1;
    end else begin
        reset_prev <= reset_active;
    end
end
assign reset_release = reset_prev && !reset_active;

// ----------------------------------------------------------------
// Mode latch, RAM control, strobe flag
// ----------------------------------------------------------------
logic [2:0] nmi_sync;
logic [2:0] strobe_sync;
logic nmi_seen;
logic strobe_seen;
logic nmi_fall;
logic strobe_fall;
logic nmi_pending;

// Mode pins caught on the release edge of reset
always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        op_config <= 3'h0;
    end else if (reset_release) begin
        op_config <= port2_mode_pins;
    end
end

// Clearing the allow bit before standby keeps the array untouched
always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        ram_access_allow <= 1'(`RAM_CTRL_RESET >> `RAM_CTRL_ALLOW_BIT);
    end else if (ram_ctrl_wr) begin
        ram_access_allow <= ram_ctrl_data[`RAM_CTRL_ALLOW_BIT];
    end
end

// Pin samples taken at E rate; edges compare agreed samples
always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        nmi_sync <= 3'h7;
        strobe_sync <= 3'h7;
        nmi_seen <= 1'b1;
        strobe_seen <= 1'b1;
    end else if (e_rise) begin
        nmi_sync <= {nmi_sync[1:0], nonmask_pin};
        strobe_sync <= {strobe_sync[1:0], port_in_strobe};
        if (nmi_sync[1] == nmi_sync[2]) begin
            nmi_seen <= nmi_sync[2];
        end
        if (strobe_sync[1] == strobe_sync[2]) begin
            strobe_seen <= strobe_sync[2];
        end
    end
end
assign nmi_fall = e_rise && nmi_seen && nmi_sync[1] == 1'b0 && nmi_sync[2] == 1'b0;
assign strobe_fall = e_rise && strobe_seen && strobe_sync[1] == 1'b0
    && strobe_sync[2] == 1'b0;

// Flag set wins over a clear in the same cycle
always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        strobe_flag <= 1'b0;
        strobe_irq_enable <= 1'b0;
    end else if (reset_active) begin
        strobe_flag <= 1'b0;
        strobe_irq_enable <= 1'b0;
    end else begin
        if (strobe_fall && single_chip_mode) begin
            strobe_flag <= 1'b1;
        end else if (strobe_flag_clear) begin
            strobe_flag <= 1'b0;
        end
        if (strobe_irq_enable_wr) begin
            strobe_irq_enable <= strobe_irq_enable_data;
        end
    end
end

// ----------------------------------------------------------------
// Priority selection
// ----------------------------------------------------------------
logic trap_req;
logic ext_req;
logic int_req;
logic any_req;
src_type next_source;

assign trap_req = address_error || opcode_error;
// Level request, sampled only at the boundary and never stored
assign ext_req = !interrupt_mask && (!external_maskable_request
    || (strobe_flag && strobe_irq_enable));
assign int_req = !interrupt_mask && (capture_event_flag || compare_event_flag
    || counter_wrap_flag || serial_unit_event);

// Fixed ranking; external examined before internal sources
assign next_source = trap_req ? SRC_TRAP
    : nmi_pending ? SRC_NONMASK
    : software_exception ? SRC_SOFTWARE
    : ext_req ? SRC_EXTERNAL
    : !int_req ? SRC_NONE
    : capture_event_flag ? SRC_CAPTURE
    : compare_event_flag ? SRC_COMPARE
    : counter_wrap_flag ? SRC_WRAP
    : SRC_SERIAL;
assign any_req = (next_source != SRC_NONE);

function automatic logic [15:0] vector_of(input src_type src);
    case (src)
        SRC_RESET: vector_of = `VEC_RESET;
        SRC_TRAP: vector_of = `VEC_TRAP;
        SRC_NONMASK: vector_of = `VEC_NONMASK;
        SRC_SOFTWARE: vector_of = `VEC_SOFTWARE;
        SRC_EXTERNAL: vector_of = `VEC_EXTERNAL;
        SRC_CAPTURE: vector_of = `VEC_CAPTURE;
        SRC_COMPARE: vector_of = `VEC_COMPARE;
        SRC_WRAP: vector_of = `VEC_WRAP;
        SRC_SERIAL: vector_of = `VEC_SERIAL;
        default: vector_of = `VEC_RESET;
    endcase
endfunction

// ----------------------------------------------------------------
// Sequencer
// ----------------------------------------------------------------
seq_state_type state;
logic [3:0] push_count;
logic [15:0] vec_base;

assign vec_base = vector_of(src_type'(service_source));
assign vector_read = (state == ST_FETCH_HI) || (state == ST_FETCH_LO);
assign stack_push = (state == ST_PUSH);
// Low byte sits one above the high byte
assign vector_addr = (state == ST_FETCH_LO) ? (vec_base | 16'h0001) : vec_base;

// Stack (or hold, after reset), then fetch two vector bytes, then run
always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        state <= ST_HOLD;
        push_count <= 4'h0;
        service_source <= SRC_RESET;
        program_counter <= 16'h0000;
        pc_valid <= 1'b0;
        interrupt_mask <= 1'b1;
        nmi_pending <= 1'b0;
    end else if (reset_active) begin
        state <= ST_HOLD;
        service_source <= SRC_RESET;
        pc_valid <= 1'b0;
        interrupt_mask <= 1'b1;
        nmi_pending <= 1'b0;
    end else begin
        if (nmi_fall) begin
            nmi_pending <= 1'b1;
        end
        case (state)
            ST_HOLD: begin
                state <= ST_FETCH_HI;
            end
            ST_FETCH_HI: begin
                program_counter[15:8] <= vector_data;
                state <= ST_FETCH_LO;
            end
            ST_FETCH_LO: begin
                program_counter[7:0] <= vector_data;
                pc_valid <= 1'b1;
                state <= ST_RUN;
            end
            ST_RUN: begin
                if (mask_clear) begin
                    interrupt_mask <= 1'b0;
                end else if (mask_set) begin
                    interrupt_mask <= 1'b1;
                end
                if (instr_boundary && any_req) begin
                    service_source <= next_source;
                    if (next_source == SRC_NONMASK && !nmi_fall) begin
                        nmi_pending <= 1'b0;
                    end
                    push_count <= 4'h0;
                    state <= ST_PUSH;
                end
            end
            ST_PUSH: begin
                push_count <= push_count + 4'h1;
                if (push_count == `PUSH_CYCLES - 4'h1) begin
                    interrupt_mask <= 1'b1;
                    state <= ST_FETCH_HI;
                end
            end
            default: begin
                state <= ST_HOLD;
            end
        endcase
    end
end

endmodule

// ---- seq_props.sv ----
`timescale 1ns/1ps
// ----
// Entry timing, vector fetch and pin floating
// ----
module seq_props (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic chip_reset_pin,
    input wire logic low_power_hold_pin,
    input wire logic instr_boundary,
    input wire logic address_error,
    input wire logic opcode_error,
    input wire logic e_clk,
    input wire logic ports_oe_n,
    input wire logic addr_oe_n,
    input wire logic [15:0] vector_addr,
    input wire logic vector_read,
    input wire logic pc_valid,
    input wire logic stack_push,
    input wire logic [3:0] service_source,
    input wire logic interrupt_mask
);
    // Vector base of the source being served; trap sits apart from the rest
    wire [15:0] exp_base = (service_source == 4'h2) ? 16'hFFEE
        : 16'h0002 - {11'h000, service_source, 1'b0};

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    chk_e_quarter: assert property (disable iff (!nrst || !low_power_hold_pin)
        $rose(e_clk) |=> e_clk ##1 !e_clk [*2] ##1 e_clk) else $error("E rate");
    chk_ports_float: assert property (
        (!chip_reset_pin || !low_power_hold_pin) |-> ports_oe_n) else $error("ports driven");
    chk_addr_float: assert property (!chip_reset_pin |-> addr_oe_n)
        else $error("address driven");
    chk_entry_boundary: assert property ($rose(stack_push) |-> $past(instr_boundary))
        else $error("entry off boundary");
    chk_push_length: assert property (
        $rose(stack_push) |-> stack_push [*7] ##1 (!stack_push && vector_read))
        else $error("stacking length");
    chk_mask_after: assert property ($fell(stack_push) |-> interrupt_mask)
        else $error("mask not set");
    chk_masked_hold: assert property (
        ($rose(stack_push) && $past(interrupt_mask)) |-> (service_source inside {2, 3, 4}))
        else $error("masked source taken");
    chk_trap_first: assert property (
        ($rose(stack_push) && ($past(address_error) || $past(opcode_error)))
        |-> service_source == 4'h2) else $error("trap not first");
    chk_vec_base: assert property (
        ($rose(vector_read) && pc_valid) |-> (vector_addr == exp_base)
        ##1 (vector_read && vector_addr == ($past(vector_addr) | 16'h0001)))
        else $error("vector address");

    cov_entry: cover property ($rose(stack_push));
    cov_ext: cover property ($rose(vector_read) && service_source == 4'h5);
    cov_standby: cover property ($fell(low_power_hold_pin));
endmodule

bind reset_interrupt_sequencer seq_props chk_u (.ref_clk, .nrst, .chip_reset_pin,
    .low_power_hold_pin, .instr_boundary, .address_error, .opcode_error, .e_clk,
    .ports_oe_n, .addr_oe_n, .vector_addr, .vector_read, .pc_valid, .stack_push,
    .service_source, .interrupt_mask);

// ---- src_model.sv ----
`timescale 1ns/1ps
// ----
// Reset, standby and edge sources
// ----
module src_model (
    input wire logic ref_clk,
    output logic chip_reset_pin,
    output logic low_power_hold_pin,
    output logic nonmask_pin,
    output logic port_in_strobe
);
    // Power-up hold, scaled down to keep the run short
    initial begin
        {low_power_hold_pin, nonmask_pin, port_in_strobe} = 3'h7;
        chip_reset_pin = 1'b0;
        repeat (40) @(negedge ref_clk);
        chip_reset_pin = 1'b1;
    end
    // Run-time reset, never shorter than three E cycles
    task automatic pulse_reset(input int n);
        chip_reset_pin = 1'b0;
        repeat (4 * ((n < 3) ? 3 : n)) @(negedge ref_clk);
        chip_reset_pin = 1'b1;
    endtask
    task automatic set(input int p, input logic v);
        if (p == 1) low_power_hold_pin = v;
        else if (p == 2) nonmask_pin = v;
        else port_in_strobe = v;
    endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
// ----
// Bench for the reset and interrupt sequencer
// ----
module tb;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [6:0] req = 7'h00;
    logic [2:0] mode = 3'h0;
    logic [7:0] rd = 8'h00;
    logic bnd = 1'b0, sel = 1'b0, mclr = 1'b0, mset = 1'b0, sewr = 1'b0, sfc = 1'b0, rwr = 1'b0;
    logic scm = 1'b1, sed = 1'b1;
    int fail_count = 0, comparisons = 0, nmi_pend = 0, strb = 0;
    wire chip_reset_pin, low_power_hold_pin, nonmask_pin, port_in_strobe, e_clk, osc_enable;
    wire ports_oe_n, addr_oe_n, vector_read, pc_valid, stack_push, interrupt_mask;
    wire strobe_flag, strobe_irq_enable, ram_access_allow;
    wire [15:0] vector_addr, program_counter;
    wire [3:0] service_source;
    wire [2:0] op_config;
    // Each vector byte is a scramble of its own address
    wire [7:0] vector_data = vector_addr[7:0] ^ 8'h3C;

    always #50 ref_clk = ~ref_clk;

    src_model src_u (.ref_clk, .chip_reset_pin, .low_power_hold_pin, .nonmask_pin,
        .port_in_strobe);
    reset_interrupt_sequencer dut_u (.ref_clk, .nrst, .chip_reset_pin, .low_power_hold_pin,
        .nonmask_pin, .external_maskable_request(~req[2]), .port_in_strobe,
        .port2_mode_pins(mode), .single_chip_mode(scm), .capture_event_flag(req[3]),
        .compare_event_flag(req[4]), .counter_wrap_flag(req[5]), .serial_unit_event(req[6]),
        .software_exception(req[1]), .address_error(req[0] & ~sel),
        .opcode_error(req[0] & sel), .instr_boundary(bnd), .mask_clear(mclr), .mask_set(mset),
        .strobe_irq_enable_wr(sewr), .strobe_irq_enable_data(sed), .strobe_flag_clear(sfc),
        .ram_ctrl_wr(rwr), .ram_ctrl_data(rd), .vector_data, .e_clk, .osc_enable, .ports_oe_n,
        .addr_oe_n, .vector_addr, .vector_read, .program_counter, .pc_valid, .stack_push,
        .service_source, .interrupt_mask, .op_config, .strobe_flag, .strobe_irq_enable,
        .ram_access_allow);

    // Expected program counter after a fetch at base b
    function automatic logic [15:0] vpc(input logic [15:0] b);
        return {b[7:0] ^ 8'h3C, (b[7:0] | 8'h01) ^ 8'h3C};
    endfunction
    // Priority model; r[7] means the mask is set
    function automatic int pick(input logic [7:0] r);
        if (r[0]) return 2;
        if (nmi_pend != 0) return 3;
        if (r[1]) return 4;
        if (r[7]) return 0;
        if (r[2] || strb != 0) return 5;
        for (int i = 3; i < 7; i++) begin
            if (r[i]) return i + 3;
        end
        return 0;
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        if (fail_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Bounded wait for the reset fetch, then the reset state
    task automatic boot();
        int n;
        n = 0;
        while (pc_valid !== 1'b1 && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 300) begin
            fail_count++;
            finish_test();
        end
        check(program_counter, vpc(16'hFFFE));
        check(16'(interrupt_mask), 16'h0001);
        check(16'(op_config), 16'(mode));
        check(16'(strobe_irq_enable), 16'h0000);
    endtask

    // One boundary with requests r; the mask is forced first, so the model knows it
    task automatic go(input logic [7:0] r);
        int e, seen;
        mset = r[7];
        mclr = ~r[7];
        @(negedge ref_clk);
        {mset, mclr} = 2'b00;
        e = pick(r);
        req = r[6:0];
        bnd = 1'b1;
        sel = ~sel;
        @(negedge ref_clk);
        {req, bnd} = 8'h00;
        seen = 0;
        repeat (12) begin
            @(negedge ref_clk);
            if (vector_read === 1'b1) seen = 1;
        end
        check(16'(seen), 16'(e != 0));
        if (e != 0) begin
            check(16'(service_source), 16'(e));
            check(program_counter, vpc(e == 2 ? 16'hFFEE : 16'h0002 - 16'(2 * e)));
            check(16'(interrupt_mask), 16'h0001);
        end
        if (e == 3) nmi_pend = 0;
    endtask

    initial begin
        int r;
        void'($urandom(32'hE944));
        mode = 3'($urandom);
        repeat (6) @(negedge ref_clk);
        nrst = 1'b1;
        boot();
        go(8'h81);
        src_u.set(2, 1'b0);
        repeat (16) @(negedge ref_clk);
        nmi_pend = 1;
        go(8'h80);
        go(8'h80);
        src_u.set(2, 1'b1);
        // One-hot sources first, then random mixes and mask states
        for (int i = 0; i < 27; i++) begin
            r = (i < 7) ? (1 << i) : $urandom;
            if (r[7]) r[1] = 1'b0;
            go(8'(r));
        end
        // Strobe edge outside single-chip mode first, then inside it
        scm = 1'b0;
        repeat (2) begin
            src_u.set(3, 1'b0);
            repeat (16) @(negedge ref_clk);
            src_u.set(3, 1'b1);
            repeat (16) @(negedge ref_clk);
            check(16'(strobe_flag), 16'(scm));
            scm = 1'b1;
        end
        // Flag set but enable still clear from reset: no entry
        go(8'h00);
        sewr = 1'b1;
        @(negedge ref_clk);
        sewr = 1'b0;
        check(16'(strobe_irq_enable), 16'h0001);
        strb = 1;
        go(8'h00);
        strb = 0;
        sfc = 1'b1;
        @(negedge ref_clk);
        sfc = 1'b0;
        @(negedge ref_clk);
        check(16'(strobe_flag), 16'h0000);
        {sewr, sed} = 2'b10;
        @(negedge ref_clk);
        sewr = 1'b0;
        check(16'(strobe_irq_enable), 16'h0000);
        repeat (4) begin
            rd = 8'($urandom);
            rwr = 1'b1;
            @(negedge ref_clk);
            rwr = 1'b0;
            check(16'(ram_access_allow), 16'(rd[6]));
            @(negedge ref_clk);
        end
        go(8'h84);
        go(8'h00);
        mode = ~mode;
        src_u.pulse_reset(3);
        check(16'(pc_valid), 16'h0000);
        boot();
        src_u.set(1, 1'b0);
        #1;
        check(16'(osc_enable), 16'h0000);
        repeat (12) @(negedge ref_clk);
        check(16'(e_clk), 16'h0000);
        check(16'(pc_valid), 16'h0000);
        src_u.set(1, 1'b1);
        boot();
        finish_test();
    end
endmodule
